/* File: mvaf_formatter.sv */
// ascii record formatter for measured-value output with apb register access
`timescale 1ns/100ps
module mvaf_formatter #(
    parameter int TAIL_MAX = 9
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire mvaf_pkg::mvaf_apb_req_t apb_i,
    output logic [31:0] apb_prdata_o,
    output logic apb_pready_o,
    output logic apb_pslverr_o,
    input wire logic edge_sw_i,
    input wire logic remote_sw_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output mvaf_pkg::mvaf_char_t tx_o,
    input wire logic tx_ready_i
);
    import mvaf_pkg::*;

    if (TAIL_MAX < 0 || TAIL_MAX > 15) begin : g_bad_tail
        $error("TAIL_MAX must fit a 4-bit field");
    end

    mvaf_state_t s;
    mvaf_state_t nx;
    logic [31:0] rd_v;
    logic addr_hit;
    logic wr_go;
    logic acc;
    logic edge_go;
    logic rem_go;
    logic rot;
    logic dms;
    logic [3:0] il;
    logic [3:0] fl;
    logic [3:0] tail;
    logic [1:0] slot;
    logic [1:0] nlines;
    logic unsigned_line;
    logic [3:0] nib;
    logic [7:0] cur_ch;

    function automatic logic [7:0] val_off(input int k, input int f);
        val_off = 8'(int'(OFF_VAL_BASE) + 8 * k + 4 * f);
    endfunction : val_off

    // label characters; the colon or equals sign closes every label
    function automatic logic [7:0] lbl_ch(input mvaf_kind_t k, input logic [1:0] ln,
                                          input logic [3:0] p, input logic [31:0] lt);
        logic [7:0] c;
        c = CH_COLON;
        unique case (k)
            MVAF_K_ROT: c = (p == 4'h0) ? lt[7:0] : CH_EQ;
            MVAF_K_EDGE: c = (p == 4'h0) ? lt[15:8] : ((p == 4'h3) ? CH_COLON : CH_SP);
            MVAF_K_CL:
            begin
                if (ln == 2'h0)
                begin
                    c = (p == 4'h0) ? CH_UC_C : ((p == 4'h1) ? CH_UC_L : lt[15:8]);
                end
                else
                begin
                    c = (p == 4'h0) ? CH_UC_D : ((p == 4'h1) ? CH_UC_S : CH_UC_T);
                end
            end
            MVAF_K_CC:
            begin
                if (ln == 2'h2)
                begin
                    c = (p == 4'h0) ? CH_UC_D : ((p == 4'h1) ? CH_UC_I : CH_UC_A);
                end
                else if (p == 4'h2)
                begin
                    c = (ln == 2'h0) ? lt[23:16] : lt[31:24];
                end
                else
                begin
                    c = CH_UC_C;
                end
            end
        endcase
        if (p == 4'h3)
        begin
            c = CH_COLON;
        end
        lbl_ch = c;
    endfunction : lbl_ch

    function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo,
                                         input logic [3:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    assign acc = s.tx.valid && tx_ready_i;
    assign wr_go = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign apb_pready_o = apb_i.psel && apb_i.penable;
    assign apb_pslverr_o = apb_pready_o && s.pslverr;
    assign apb_prdata_o = s.prdata;
    assign tx_o = s.tx;

    always_comb
    begin
        rot = (s.kind == MVAF_K_ROT);
        dms = rot && s.ctrl[CTRL_DMS];
        tail = s.ctrl[CTRL_TAIL_LSB +: 4];
        if (tail > 4'(TAIL_MAX))
        begin
            tail = 4'(TAIL_MAX);
        end
        if (dms)
        begin
            il = clamp(s.fmt[FMT_INT_LSB +: 4], DMS_INT_MIN, INT_MAX_ROT);
            fl = clamp({1'b0, s.fmt[FMT_FRAC_LSB +: 3]}, 4'h0, DMS_MIN_DIGITS + DMS_MIN_DIGITS);
        end
        else if (rot)
        begin
            il = clamp(s.fmt[FMT_INT_LSB +: 4], 4'h1, INT_MAX_ROT);
            fl = clamp({1'b0, s.fmt[FMT_FRAC_LSB +: 3]}, 4'h0, FRAC_MAX_ROT);
        end
        else
        begin
            il = clamp(s.fmt[FMT_INT_LSB +: 4], INT_MIN_PRB, INT_MAX_PRB);
            fl = clamp({1'b0, s.fmt[FMT_FRAC_LSB +: 3]}, 4'h1, FRAC_MAX_PRB);
        end
        slot = (s.kind == MVAF_K_CL || s.kind == MVAF_K_CC) ? s.line : 2'h0;
        nlines = (s.kind == MVAF_K_CC) ? 2'h3 : ((s.kind == MVAF_K_CL) ? 2'h2 : 2'h1);
        unsigned_line = (s.kind == MVAF_K_CL && s.line == 2'h1) ||
                        (s.kind == MVAF_K_CC && s.line == 2'h2);
        nib = 4'h0;
        if (s.st == ST_INT)
        begin
            nib = s.vint[slot][s.idx * 4 +: 4];
        end
        else if (s.st == ST_FRAC && s.idx < 4'h6)
        begin
            nib = s.vfrac[slot][(5 - int'(s.idx)) * 4 +: 4];
        end
        unique case (s.st)
            ST_IDLE: cur_ch = CH_SP;
            ST_LBL: cur_ch = lbl_ch(s.kind, s.line, s.idx, s.letters);
            ST_SIGN: cur_ch = unsigned_line ? CH_SP :
                              (s.vfrac[slot][VAL_NEG_BIT] ? CH_MINUS : CH_PLUS);
            ST_INT, ST_FRAC: cur_ch = CH_ZERO | {4'h0, nib};
            ST_DOT: cur_ch = dms ? CH_COLON : CH_DOT;
            ST_SEP: cur_ch = CH_COLON;
            ST_SUF0: cur_ch = (!rot && s.ctrl[CTRL_INCH]) ? CH_QUOTE : CH_SP;
            ST_SUF1: cur_ch = (rot ? CH_UC_W : (s.ctrl[CTRL_DIA] ? CH_UC_D : CH_UC_R)) |
                              (s.ctrl[CTRL_DTG] ? CH_LOWER : 8'h00);
            ST_CR, ST_TAIL: cur_ch = CH_CR;
            ST_LF: cur_ch = CH_LF;
            default: cur_ch = CH_SP;
        endcase
    end

    always_comb
    begin
        nx = s;
        addr_hit = (apb_i.paddr == OFF_CTRL) || (apb_i.paddr == OFF_LETTERS) ||
                   (apb_i.paddr == OFF_FMT) || (apb_i.paddr == OFF_STATUS) ||
                   (apb_i.paddr >= OFF_VAL_BASE && apb_i.paddr < OFF_VAL_END &&
                    apb_i.paddr[1:0] == 2'h0);
        rd_v = 32'h0000_0000;
        if (apb_i.paddr == OFF_CTRL) rd_v = s.ctrl;
        if (apb_i.paddr == OFF_LETTERS) rd_v = s.letters;
        if (apb_i.paddr == OFF_FMT) rd_v = s.fmt;
        if (apb_i.paddr == OFF_STATUS)
        begin
            rd_v[STAT_BUSY] = (s.st != ST_IDLE);
            rd_v[STAT_CNT_LSB +: 8] = s.rec_cnt;
        end
        for (int k = 0; k < VAL_SLOTS; k++)
        begin
            if (apb_i.paddr == val_off(k, 0)) rd_v = s.vint[k];
            if (apb_i.paddr == val_off(k, 1)) rd_v = s.vfrac[k];
        end
        if (apb_i.psel && !apb_i.penable)
        begin
            nx.prdata = rd_v;
            nx.pslverr = !addr_hit;
        end
        if (wr_go && addr_hit)
        begin
            if (apb_i.paddr == OFF_CTRL) nx.ctrl = apb_i.pwdata;
            if (apb_i.paddr == OFF_LETTERS) nx.letters = apb_i.pwdata;
            if (apb_i.paddr == OFF_FMT) nx.fmt = apb_i.pwdata;
            for (int k = 0; k < VAL_SLOTS; k++)
            begin
                if (apb_i.paddr == val_off(k, 0)) nx.vint[k] = apb_i.pwdata;
                if (apb_i.paddr == val_off(k, 1)) nx.vfrac[k] = apb_i.pwdata;
            end
        end

        nx.ef_sync = {s.ef_sync[0], edge_sw_i};
        nx.rs_sync = {s.rs_sync[0], remote_sw_i};
        nx.ef_d = s.ef_sync[1];
        nx.rs_d = s.rs_sync[1];
        edge_go = s.ef_sync[1] && !s.ef_d && s.ctrl[CTRL_MVO_EN];
        rem_go = (s.rs_sync[1] && !s.rs_d) || (rx_valid_i && rx_data_i == CH_CTRL_B);

        if (s.st == ST_IDLE)
        begin
            if (edge_go || rem_go)
            begin
                nx.st = ST_LBL;
                nx.idx = 4'h0;
                nx.line = 2'h0;
                nx.sepd = 1'b0;
                if (edge_go)
                begin
                    nx.kind = (s.fmt[FMT_KIND_LSB +: 2] == 2'h3) ? MVAF_K_EDGE :
                              mvaf_kind_t'(s.fmt[FMT_KIND_LSB +: 2]);
                end
                else
                begin
                    nx.kind = MVAF_K_ROT;
                end
            end
        end
        else if (!s.tx.valid)
        begin
            nx.tx.data = cur_ch;
            nx.tx.valid = 1'b1;
        end
        else if (acc)
        begin
            nx.tx.valid = 1'b0;
            unique case (s.st)
                ST_LBL:
                begin
                    nx.idx = s.idx + 4'h1;
                    if (s.idx == (rot ? 4'h1 : 4'h3)) nx.st = ST_SIGN;
                end
                ST_SIGN:
                begin
                    nx.st = ST_INT;
                    nx.idx = il - 4'h1;
                end
                ST_INT:
                begin
                    nx.idx = s.idx - 4'h1;
                    if (s.idx == 4'h0) nx.st = ST_DOT;
                end
                ST_DOT:
                begin
                    nx.idx = 4'h0;
                    nx.st = (fl == 4'h0) ? (dms ? ST_SEP : ST_SUF0) : ST_FRAC;
                end
                ST_FRAC:
                begin
                    nx.idx = s.idx + 4'h1;
                    if (dms && !s.sepd && (s.idx + 4'h1 == DMS_MIN_DIGITS || s.idx + 4'h1 >= fl))
                        nx.st = ST_SEP;
                    else if (s.idx + 4'h1 >= fl)
                        nx.st = ST_SUF0;
                end
                ST_SEP:
                begin
                    nx.sepd = 1'b1;
                    nx.st = (s.idx >= fl) ? ST_SUF0 : ST_FRAC;
                end
                ST_SUF0: nx.st = ST_SUF1;
                ST_SUF1: nx.st = ST_CR;
                ST_CR: nx.st = ST_LF;
                ST_LF:
                begin
                    if (s.line + 2'h1 < nlines)
                    begin
                        nx.line = s.line + 2'h1;
                        nx.idx = 4'h0;
                        nx.st = ST_LBL;
                    end
                    else if (tail != 4'h0)
                    begin
                        nx.tail_left = tail;
                        nx.st = ST_TAIL;
                    end
                    else
                    begin
                        nx.st = ST_IDLE;
                        nx.rec_cnt = s.rec_cnt + 8'h01;
                    end
                end
                ST_TAIL:
                begin
                    nx.tail_left = s.tail_left - 4'h1;
                    if (s.tail_left == 4'h1)
                    begin
                        nx.st = ST_IDLE;
                        nx.rec_cnt = s.rec_cnt + 8'h01;
                    end
                end
                default: nx.st = ST_IDLE;
            endcase
        end

        if (sys_rst_i)
        begin
            nx = '0;
            nx.ctrl = CTRL_RST;
            nx.letters = LETTERS_RST;
            nx.fmt = FMT_RST;
            nx.st = ST_IDLE;
            nx.kind = MVAF_K_EDGE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= nx;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_cr_then_lf: assert property ((acc && s.st == ST_CR) |-> ##[1:2]
        (s.tx.valid && s.tx.data == CH_LF)) else $error("CR not followed by LF");
    a_char_hold: assert property ((s.tx.valid && !tx_ready_i) |=>
        (s.tx.valid && $stable(s.tx.data))) else $error("character changed before ready");
    a_gate_off: assert property ((s.st == ST_IDLE && !s.ctrl[CTRL_MVO_EN] && !rem_go) |=>
        s.st == ST_IDLE) else $error("edge record sent while output disabled");
    a_edge_start: assert property ((s.st == ST_IDLE && edge_go) |=>
        (s.st == ST_LBL && s.kind != MVAF_K_ROT)) else $error("edge finder did not start record");
    a_ctrlb_start: assert property ((s.st == ST_IDLE && !edge_go && rem_go) |=>
        (s.st == ST_LBL && s.kind == MVAF_K_ROT)) else $error("remote trigger lost");
    a_busy_ignore: assert property ((s.st != ST_IDLE && (edge_go || rem_go)) |=>
        ($stable(s.kind) && (s.st != ST_LBL || $past(s.st) == ST_LBL ||
         $past(s.st) == ST_LF))) else $error("record restarted while busy");
    a_rot_mark: assert property ((rot && s.st == ST_SUF1 && s.tx.valid) |->
        s.tx.data == (s.ctrl[CTRL_DTG] ? (CH_UC_W | CH_LOWER) : CH_UC_W))
        else $error("wrong angle marker");
    a_probe_unit: assert property ((!rot && s.st == ST_SUF0 && s.tx.valid) |->
        s.tx.data == (s.ctrl[CTRL_INCH] ? CH_QUOTE : CH_SP)) else $error("wrong unit character");
    a_probe_mark: assert property ((!rot && s.st == ST_SUF1 && s.tx.valid)
        |-> s.tx.data == ((s.ctrl[CTRL_DIA] ? CH_UC_D : CH_UC_R) |
        (s.ctrl[CTRL_DTG] ? CH_LOWER : 8'h00))) else $error("wrong radius or diameter marker");
    a_dst_blank: assert property ((s.kind == MVAF_K_CL && s.line == 2'h1 &&
        s.st == ST_SIGN && s.tx.valid) |-> s.tx.data == CH_SP) else $error("DST line has a sign");
    a_int_width: assert property ((s.st == ST_INT) |->
        s.idx < INT_MAX_ROT) else $error("more than eight integer digits");
endmodule : mvaf_formatter

/* File: mvaf_pkg.sv */
// constants, register map and types of the measured-value ascii formatter
package mvaf_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LETTERS = 8'h04;
    localparam logic [7:0] OFF_FMT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_VAL_BASE = 8'h10;
    localparam logic [7:0] OFF_VAL_END = 8'h28;
    localparam int VAL_SLOTS = 3;
    localparam int CTRL_MVO_EN = 0;
    localparam int CTRL_INCH = 1;
    localparam int CTRL_DIA = 2;
    localparam int CTRL_DTG = 3;
    localparam int CTRL_DMS = 4;
    localparam int CTRL_TAIL_LSB = 8;
    localparam int FMT_INT_LSB = 0;
    localparam int FMT_FRAC_LSB = 4;
    localparam int FMT_KIND_LSB = 8;
    localparam int VAL_NEG_BIT = 31;
    localparam int STAT_BUSY = 0;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LETTERS_RST = 32'h5958_5843;
    localparam logic [31:0] FMT_RST = 32'h0000_0044;
    localparam logic [3:0] INT_MAX_ROT = 4'h8;
    localparam logic [3:0] INT_MIN_PRB = 4'h2;
    localparam logic [3:0] INT_MAX_PRB = 4'h7;
    localparam logic [3:0] FRAC_MAX_ROT = 4'h4;
    localparam logic [3:0] FRAC_MAX_PRB = 4'h6;
    localparam logic [3:0] DMS_INT_MIN = 4'h3;
    localparam logic [3:0] DMS_MIN_DIGITS = 4'h2;
    localparam logic [7:0] CH_EQ = 8'h3d;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_QUOTE = 8'h22;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_CTRL_B = 8'h02;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_LOWER = 8'h20;
    localparam logic [7:0] CH_UC_A = 8'h41;
    localparam logic [7:0] CH_UC_C = 8'h43;
    localparam logic [7:0] CH_UC_D = 8'h44;
    localparam logic [7:0] CH_UC_I = 8'h49;
    localparam logic [7:0] CH_UC_L = 8'h4c;
    localparam logic [7:0] CH_UC_R = 8'h52;
    localparam logic [7:0] CH_UC_S = 8'h53;
    localparam logic [7:0] CH_UC_T = 8'h54;
    localparam logic [7:0] CH_UC_W = 8'h57;

    typedef enum logic [1:0] {MVAF_K_EDGE, MVAF_K_CL, MVAF_K_CC, MVAF_K_ROT} mvaf_kind_t;
    typedef enum logic [3:0] {ST_IDLE, ST_LBL, ST_SIGN, ST_INT, ST_DOT, ST_FRAC, ST_SEP,
        ST_SUF0, ST_SUF1, ST_CR, ST_LF, ST_TAIL} mvaf_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } mvaf_apb_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } mvaf_char_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] letters;
        logic [31:0] fmt;
        logic [VAL_SLOTS-1:0][31:0] vint;
        logic [VAL_SLOTS-1:0][31:0] vfrac;
        logic [31:0] prdata;
        logic pslverr;
        logic [1:0] ef_sync;
        logic [1:0] rs_sync;
        logic ef_d;
        logic rs_d;
        mvaf_st_t st;
        mvaf_kind_t kind;
        logic [1:0] line;
        logic [3:0] idx;
        logic sepd;
        logic [3:0] tail_left;
        logic [7:0] rec_cnt;
        mvaf_char_t tx;
    } mvaf_state_t;
endpackage : mvaf_pkg

/* File: mvaf_rx_model.sv */
// receiving terminal model: takes characters, optionally stalling between them
`timescale 1ns/100ps
module mvaf_rx_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire mvaf_pkg::mvaf_char_t tx_i,
    input wire logic slow_i,
    output logic tx_ready_o
);
    import mvaf_pkg::*;
    logic [1:0] div;
    logic [7:0] q[$];
    // slow mode: ready only one cycle in four
    assign tx_ready_o = !sys_rst_i && (!slow_i || div == 2'h3);
    always @(posedge clk_i)
    begin
        div <= sys_rst_i ? 2'h0 : div + 2'h1;
        if (!sys_rst_i && tx_i.valid && tx_ready_o)
        begin
            q.push_back(tx_i.data);
        end
    end
endmodule : mvaf_rx_model

/* File: placeholder_unused.sv */
// empty compilation unit kept for folder listing
`timescale 1ns/100ps

/* File: testbench.sv */
// self-checking bench of the measured-value ascii formatter
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
    import mvaf_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    mvaf_apb_req_t apb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic edge_sw = 1'b0;
    logic remote_sw = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    mvaf_char_t tx;
    logic tx_ready;
    logic slow = 1'b0;
    logic [31:0] d;
    logic e;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    mvaf_formatter mvaf_formatter_inst (.clk_i(clk), .sys_rst_i(sys_rst), .apb_i(apb),
        .apb_prdata_o(prdata), .apb_pready_o(pready), .apb_pslverr_o(pslverr),
        .edge_sw_i(edge_sw), .remote_sw_i(remote_sw), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .tx_o(tx), .tx_ready_i(tx_ready));
    mvaf_rx_model mvaf_rx_model_inst (.clk_i(clk), .sys_rst_i(sys_rst), .tx_i(tx),
        .slow_i(slow), .tx_ready_o(tx_ready));

    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 100)
        begin
            k++;
            @(posedge clk);
        end
        if (k >= 100) n_mismatch++;
        d = prdata;
        e = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb_xfer(1'b1, a, wd);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb_xfer(1'b0, a, 32'h0);
    endtask : rd

    // hold the pin long enough to pass the synchronisers
    task automatic pulse(input logic is_edge);
        @(posedge clk);
        if (is_edge) edge_sw <= 1'b1;
        else remote_sw <= 1'b1;
        repeat (6) @(posedge clk);
        edge_sw <= 1'b0;
        remote_sw <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse

    task automatic ctrl_b();
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= CH_CTRL_B;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask : ctrl_b

    // wait for the record, then a quiet spell to catch stray characters
    task automatic check_rec(input string s);
        int i;
        i = 0;
        while (mvaf_rx_model_inst.q.size() < s.len() && i < 3000)
        begin
            i++;
            @(posedge clk);
        end
        repeat (60) @(posedge clk);
        `CHK(mvaf_rx_model_inst.q.size(), s.len())
        for (i = 0; i < s.len() && i < mvaf_rx_model_inst.q.size(); i++)
        begin
            `CHK(mvaf_rx_model_inst.q[i], s[i])
        end
        mvaf_rx_model_inst.q.delete();
        $display("test done: record of %0d chars", s.len());
    endtask : check_rec

    task automatic set_val(input int slot, input logic [31:0] vi, input logic [31:0] vf);
        wr(OFF_VAL_BASE + 8'(8 * slot), vi);
        wr(OFF_VAL_BASE + 8'(8 * slot + 4), vf);
    endtask : set_val

    task automatic final_report();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_CTRL);
        `CHK(d, CTRL_RST)
        rd(OFF_LETTERS);
        `CHK(d, LETTERS_RST)
        rd(OFF_FMT);
        `CHK(d, FMT_RST)
        rd(8'h40);
        `CHK({e, d}, 33'h1_0000_0000)
        rd(8'h01);
        `CHK(e, 1'b1)
        wr(OFF_STATUS, 32'hffff_ffff);
        rd(OFF_STATUS);
        `CHK(d, 32'h0)
        $display("test done: registers");
        slow <= 1'b1;
        wr(OFF_CTRL, 32'h0000_0200);
        set_val(0, 32'h0000_1260, 32'h0);
        pulse(1'b0);
        rd(OFF_STATUS);
        `CHK(d[STAT_BUSY], 1'b1)
        pulse(1'b0);
        ctrl_b();
        check_rec("C=+1260.0000 W\r\n\r\r");
        slow <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0008);
        wr(OFF_FMT, 32'h0000_0028);
        set_val(0, 32'h1234_5678, 32'h8090_0000);
        ctrl_b();
        check_rec("C=-12345678.90 w\r\n");
        wr(OFF_CTRL, 32'h0000_0f10);
        wr(OFF_FMT, 32'h0000_0043);
        set_val(0, 32'h0000_0360, 32'h0023_4500);
        pulse(1'b0);
        check_rec("C=+360:23:45 W\r\n\r\r\r\r\r\r\r\r\r");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_FMT, 32'h0000_0044);
        pulse(1'b1);
        check_rec("");
        wr(OFF_CTRL, 32'h0000_0009);
        wr(OFF_LETTERS, 32'h5958_5943);
        set_val(0, 32'h0000_3674, 32'h8044_9800);
        pulse(1'b1);
        check_rec("Y  :-3674.4498 r\r\n");
        wr(OFF_CTRL, 32'h0000_0007);
        wr(OFF_LETTERS, LETTERS_RST);
        wr(OFF_FMT, 32'h0000_0144);
        set_val(0, 32'h0000_3476, 32'h0099_6300);
        set_val(1, 32'h0000_2853, 32'h0000_1200);
        pulse(1'b1);
        check_rec("CLX:+3476.9963\"D\r\nDST: 2853.0012\"D\r\n");
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_LETTERS, 32'h5a59_5843);
        wr(OFF_FMT, 32'h0000_0244);
        set_val(0, 32'h0000_1616, 32'h8034_2900);
        set_val(1, 32'h0000_4362, 32'h0098_7600);
        set_val(2, 32'h0000_1250, 32'h0005_0000);
        pulse(1'b1);
        check_rec("CCY:-1616.3429 R\r\nCCZ:+4362.9876 R\r\nDIA: 1250.0500 R\r\n");
        rd(OFF_STATUS);
        `CHK(d[15:0], 16'h0600)
        final_report();
    end
endmodule : testbench
